/* src/ssw_defs.svh */
// Constants of the servo setup word block
`ifndef SSW_DEFS_SVH
`define SSW_DEFS_SVH

// Word shape and factory contents
`define SSW_WORD_W     16
`define SSW_BITNUM_W   4
`define SSW_FACTORY    16'h08ec
`define SSW_BITNUM_RST 4'h0

// Bit positions of the sequence setup word
`define SSW_B_SERVO_ON 0
`define SSW_B_FWD_IGN  2
`define SSW_B_REV_IGN  3
`define SSW_B_LIMIT    4
`define SSW_B_DIP_AUTO 5
`define SSW_B_COAST    6
`define SSW_B_HOLD_DB  7
`define SSW_B_OT_TORQ  8
`define SSW_B_OT_LOCK  9
`define SSW_B_KEEP_DEV 10
`define SSW_B_NO_PSW   11
`define SSW_B_PSW_LO   12
`define SSW_B_PSW_HI   13

// Width of the synchronised pin group
`define SSW_PIN_W      10

`endif

/* src/ssw_pkg.sv */
// Types shared by the servo setup word block
package ssw_pkg;

   typedef enum logic [1:0] {
      VIEW_NUM   = 2'b00,
      VIEW_BITS  = 2'b01,
      VIEW_SAVED = 2'b10
   } ssw_view_t;

   typedef struct packed {
      logic up;
      logic down;
      logic left;
      logic right;
      logic mode;
      logic data;
   } ssw_keys_t;

   typedef struct packed {
      ssw_keys_t keys;
      logic      mounted;
      logic      run;
      logic      fwd_inh;
      logic      rev_inh;
   } ssw_pins_t;

   typedef struct packed {
      logic [15:0] torque;
      logic [15:0] speed;
      logic [15:0] accel;
      logic [15:0] dev;
   } ssw_lvl_t;

endpackage : ssw_pkg

/* src/ssw_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module ssw_sync #(
   parameter int W = 10
) (
   // Clock and reset
   input  wire logic         ref_clk_i,
   input  wire logic         reset_n_i,
   // Pins and filtered levels
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;

   // A change counts only once stages two and three agree
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         s1_ff   <= '0;
         s2_ff   <= '0;
         s3_ff   <= '0;
         level_o <= '0;
      end
      else
      begin
         s1_ff <= pin_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         for (int i = 0; i < W; i++)
         begin
            if (s2_ff[i] == s3_ff[i])
               level_o[i] <= s3_ff[i];
         end
      end
   end

endmodule : ssw_sync

`default_nettype wire

/* src/ssw_pswitch.sv */
// Proportional-only switch condition selector
`timescale 1ns/1ps
`default_nettype none

module ssw_pswitch (
   // Clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             reset_n_i,
   // Setup controls
   input  wire logic             enable_i,
   input  wire logic [1:0]       cond_sel_i,
   // Live quantities and their switch levels
   input  wire ssw_pkg::ssw_lvl_t cmd_i,
   input  wire ssw_pkg::ssw_lvl_t lvl_i,
   // Speed loop mode
   output logic                  p_only_o
);

   logic [15:0] val;
   logic [15:0] lim;

   // Selector order d,C: torque, speed, accel, deviation
   assign val = (cond_sel_i == 2'h0) ? cmd_i.torque :
                (cond_sel_i == 2'h1) ? cmd_i.speed  :
                (cond_sel_i == 2'h2) ? cmd_i.accel  : cmd_i.dev;
   assign lim = (cond_sel_i == 2'h0) ? lvl_i.torque :
                (cond_sel_i == 2'h1) ? lvl_i.speed  :
                (cond_sel_i == 2'h2) ? lvl_i.accel  : lvl_i.dev;

   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         p_only_o <= 1'b0;
      else
         p_only_o <= enable_i && (val >= lim);
   end

endmodule : ssw_pswitch

`default_nettype wire

/* src/ssw_top.sv */
// Sequence setup word: keypad editing, power-up copy and sequence decode
`timescale 1ns/1ps
`default_nettype none
`include "ssw_defs.svh"

module ssw_top (
   // Clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              reset_n_i,
   // Keypad and sequence pins
   input  wire ssw_pkg::ssw_pins_t pin_i,
   // Nonvolatile memory
   input  wire logic [15:0]       nv_rdata_i,
   input  wire logic              nv_blank_i,
   output logic                   nv_wr_o,
   output logic [15:0]            nv_wdata_o,
   // Keypad display
   output logic [15:0]            disp_bits_o,
   output logic [3:0]             disp_bitnum_o,
   output logic                   disp_num_view_o,
   output logic [15:0]            live_word_o,
   // Drive status from the control core
   input  wire logic              rotating_i,
   input  wire logic              current_limit_i,
   input  wire logic              dip_recover_i,
   input  wire logic              alarm_reset_i,
   input  wire logic              ext_alarm_i,
   input  wire logic              abnormal_i,
   input  wire logic              motor_stopped_i,
   input  wire logic [15:0]       stop_torque_level_i,
   input  wire ssw_pkg::ssw_lvl_t cmd_i,
   input  wire ssw_pkg::ssw_lvl_t switch_level_i,
   // Sequence controls
   output logic                   servo_on_o,
   output logic                   fwd_block_o,
   output logic                   rev_block_o,
   output logic                   motion_or_limit_flag_o,
   output logic                   dip_alarm_o,
   output logic                   dyn_brake_o,
   output logic                   coast_o,
   output logic [15:0]            stop_torque_o,
   output logic                   pos_lock_o,
   output logic                   ot_servo_off_o,
   output logic                   dev_clear_o,
   output logic                   p_only_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [15:0] bit_mask(input logic [3:0] n);
      bit_mask = 16'h0001 << n;
   endfunction : bit_mask

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and key presses

   ssw_pkg::ssw_pins_t pin_q;
   ssw_pkg::ssw_keys_t key_prev_ff;
   ssw_pkg::ssw_keys_t press;

   ssw_sync #(
      .W (`SSW_PIN_W)
   ) u_sync (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .pin_i     (pin_i),
      .level_o   (pin_q)
   );

   assign press = pin_q.keys & ~key_prev_ff;

   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         key_prev_ff <= '0;
      else
         key_prev_ff <= pin_q.keys;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Key meaning per keypad kind

   logic hand;
   logic k_inc;
   logic k_dec;
   logic k_inv;
   logic k_commit;

   assign hand     = !pin_q.mounted;
   assign k_inc    = hand ? press.left : press.up;
   assign k_dec    = hand ? press.right : press.down;
   assign k_inv    = hand ? (press.up | press.down) : press.mode;
   assign k_commit = hand ? (press.mode | press.data) : press.data;

   ////////////////////////////////////////////////////////////////////////////
   // Power-up capture and editing

   ssw_pkg::ssw_view_t view_ff;
   ssw_pkg::ssw_view_t nxt_view;
   logic        cap_done_ff;
   logic [15:0] live_ff;
   logic [15:0] stored_ff;
   logic [15:0] edit_ff;
   logic [15:0] nxt_edit;
   logic [3:0]  bitnum_ff;
   logic [3:0]  nxt_bitnum;
   logic [15:0] boot_word;
   logic        do_commit;

   // Blank memory falls back to the factory word
   assign boot_word = nv_blank_i ? `SSW_FACTORY : nv_rdata_i;
   assign do_commit = (view_ff == ssw_pkg::VIEW_BITS) && k_commit;

   always_comb
   begin
      nxt_view   = view_ff;
      nxt_edit   = edit_ff;
      nxt_bitnum = bitnum_ff;
      case (view_ff)
         ssw_pkg::VIEW_NUM:
         begin
            if (press.data)
            begin
               nxt_view   = ssw_pkg::VIEW_BITS;
               nxt_edit   = stored_ff;
               nxt_bitnum = `SSW_BITNUM_RST;
            end
         end
         ssw_pkg::VIEW_BITS:
         begin
            if (k_commit)
               nxt_view = ssw_pkg::VIEW_SAVED;
            else if (k_inv)
               nxt_edit = edit_ff ^ bit_mask(bitnum_ff);
            else if (k_inc)
               nxt_bitnum = bitnum_ff + 4'h1;
            else if (k_dec)
               nxt_bitnum = bitnum_ff - 4'h1;
         end
         ssw_pkg::VIEW_SAVED:
         begin
            if (press.data)
               nxt_view = ssw_pkg::VIEW_NUM;
         end
         default:
            nxt_view = ssw_pkg::VIEW_NUM;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         cap_done_ff <= 1'b0;
         live_ff     <= `SSW_FACTORY;
         stored_ff   <= `SSW_FACTORY;
         edit_ff     <= `SSW_FACTORY;
         bitnum_ff   <= `SSW_BITNUM_RST;
         view_ff     <= ssw_pkg::VIEW_NUM;
         nv_wr_o     <= 1'b0;
         nv_wdata_o  <= `SSW_FACTORY;
      end
      else
      begin
         nv_wr_o <= do_commit;
         if (!cap_done_ff)
         begin
            // Live copy is loaded once; edits never reach it
            cap_done_ff <= 1'b1;
            live_ff     <= boot_word;
            stored_ff   <= boot_word;
            edit_ff     <= boot_word;
         end
         else
         begin
            if (do_commit)
            begin
               stored_ff  <= edit_ff;
               nv_wdata_o <= edit_ff;
            end
            edit_ff   <= nxt_edit;
            bitnum_ff <= nxt_bitnum;
            view_ff   <= nxt_view;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequence decode from the live copy; bits 1, E, F feed nothing

   logic alarm_any;
   logic fwd_ot;
   logic rev_ot;
   logic ot;
   logic abn;
   logic nxt_son;
   logic nxt_brake;
   logic nxt_coast;
   logic ot_torq;
   logic ot_lock;
   logic ot_off;
   logic nxt_dip;
   logic brake_after;
   logic stopping_abn;

   assign alarm_any    = dip_alarm_o | ext_alarm_i;
   assign fwd_ot       = !live_ff[`SSW_B_FWD_IGN] && pin_q.fwd_inh;
   assign rev_ot       = !live_ff[`SSW_B_REV_IGN] && pin_q.rev_inh;
   assign ot           = fwd_ot || rev_ot;
   assign abn          = abnormal_i || alarm_any;
   assign ot_torq      = ot && live_ff[`SSW_B_OT_TORQ];
   // Abnormal stop, or over-travel when bit 8 defers to bit 6
   assign stopping_abn = abn || (ot && !ot_torq);
   assign ot_lock      = ot_torq && motor_stopped_i && live_ff[`SSW_B_OT_LOCK];
   assign ot_off       = ot_torq && motor_stopped_i && !live_ff[`SSW_B_OT_LOCK];
   assign nxt_son      = (live_ff[`SSW_B_SERVO_ON] || pin_q.run)
                         && !alarm_any && !ot_off;
   // Coasting with bit 8 clear always drops the brake after stop
   assign brake_after  = live_ff[`SSW_B_HOLD_DB]
                         && !(live_ff[`SSW_B_COAST] && !live_ff[`SSW_B_OT_TORQ]);
   assign nxt_brake    = motor_stopped_i ? ((stopping_abn || ot) && brake_after)
                         : (stopping_abn && !live_ff[`SSW_B_COAST]);
   assign nxt_coast    = stopping_abn && !motor_stopped_i && live_ff[`SSW_B_COAST];
   // Set wins over a simultaneous reset request
   assign nxt_dip      = (dip_recover_i && !live_ff[`SSW_B_DIP_AUTO]) ? 1'b1 :
                         alarm_reset_i ? 1'b0 : dip_alarm_o;

   ssw_pswitch u_psw (
      .ref_clk_i  (ref_clk_i),
      .reset_n_i  (reset_n_i),
      .enable_i   (!live_ff[`SSW_B_NO_PSW]),
      .cond_sel_i (live_ff[`SSW_B_PSW_HI:`SSW_B_PSW_LO]),
      .cmd_i      (cmd_i),
      .lvl_i      (switch_level_i),
      .p_only_o   (p_only_o)
   );

   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         servo_on_o             <= 1'b0;
         fwd_block_o            <= 1'b0;
         rev_block_o            <= 1'b0;
         motion_or_limit_flag_o <= 1'b0;
         dip_alarm_o            <= 1'b0;
         dyn_brake_o            <= 1'b0;
         coast_o                <= 1'b0;
         stop_torque_o          <= 16'h0000;
         pos_lock_o             <= 1'b0;
         ot_servo_off_o         <= 1'b0;
         dev_clear_o            <= 1'b0;
      end
      else
      begin
         servo_on_o             <= nxt_son;
         fwd_block_o            <= fwd_ot;
         rev_block_o            <= rev_ot;
         motion_or_limit_flag_o <= live_ff[`SSW_B_LIMIT] ? current_limit_i
                                                          : rotating_i;
         dip_alarm_o            <= nxt_dip;
         dyn_brake_o            <= nxt_brake;
         coast_o                <= nxt_coast;
         stop_torque_o          <= (ot_torq && !motor_stopped_i) ?
                                   stop_torque_level_i : 16'h0000;
         pos_lock_o             <= ot_lock;
         ot_servo_off_o         <= ot_off;
         dev_clear_o            <= alarm_any && !nxt_son
                                   && !live_ff[`SSW_B_KEEP_DEV];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Display and readback

   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         disp_bits_o     <= 16'h0000;
         disp_bitnum_o   <= 4'h0;
         disp_num_view_o <= 1'b1;
         live_word_o     <= 16'h0000;
      end
      else
      begin
         disp_bits_o     <= edit_ff;
         disp_bitnum_o   <= bitnum_ff;
         disp_num_view_o <= (view_ff == ssw_pkg::VIEW_NUM);
         live_word_o     <= live_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_saved_data;
      cap_done_ff && (view_ff == ssw_pkg::VIEW_SAVED) && press.data;
   endsequence

   sequence s_back_to_num;
      (view_ff == ssw_pkg::VIEW_NUM) ##1 disp_num_view_o;
   endsequence

   property p_live_frozen;
      cap_done_ff && $past(cap_done_ff) |-> $stable(live_ff);
   endproperty
   a_live_frozen: assert property (p_live_frozen)
      else $error("live word changed after capture");

   property p_capture;
      !cap_done_ff |=> live_ff == $past(boot_word) && cap_done_ff;
   endproperty
   a_capture: assert property (p_capture)
      else $error("power-up capture wrong");

   property p_invert;
      cap_done_ff && view_ff == ssw_pkg::VIEW_BITS && !k_commit && k_inv
      |=> edit_ff == ($past(edit_ff) ^ bit_mask($past(bitnum_ff)));
   endproperty
   a_invert: assert property (p_invert)
      else $error("bit invert wrong");

   property p_commit;
      cap_done_ff && do_commit
      |=> nv_wr_o && nv_wdata_o == $past(edit_ff) ##1 !nv_wr_o;
   endproperty
   a_commit: assert property (p_commit)
      else $error("commit did not write word");

   property p_mount_move;
      cap_done_ff && pin_q.mounted && view_ff == ssw_pkg::VIEW_BITS
      && press.up && !press.data && !press.mode
      |=> bitnum_ff == 4'($past(bitnum_ff) + 4'h1);
   endproperty
   a_mount_move: assert property (p_mount_move)
      else $error("mounted up key did not move bit");

   property p_return;
      s_saved_data |=> s_back_to_num;
   endproperty
   a_return: assert property (p_return)
      else $error("data key did not return to number view");

   property p_servo_src;
      servo_on_o |-> $past(live_ff[`SSW_B_SERVO_ON] || pin_q.run);
   endproperty
   a_servo_src: assert property (p_servo_src)
      else $error("servo on without source");

   property p_brake_release;
      live_ff[`SSW_B_COAST] && !live_ff[`SSW_B_OT_TORQ] && motor_stopped_i
      |=> !dyn_brake_o;
   endproperty
   a_brake_release: assert property (p_brake_release)
      else $error("brake held after coast stop");

   property p_no_pswitch;
      cap_done_ff && live_ff[`SSW_B_NO_PSW] ##1 live_ff[`SSW_B_NO_PSW] |=> !p_only_o;
   endproperty
   a_no_pswitch: assert property (p_no_pswitch)
      else $error("proportional switch while disabled");

   property p_status_route;
      ##1 motion_or_limit_flag_o == $past(live_ff[`SSW_B_LIMIT] ? current_limit_i
                                                                : rotating_i);
   endproperty
   a_status_route: assert property (p_status_route)
      else $error("status flag routed wrong");

endmodule : ssw_top

`default_nettype wire

/* bench/ssw_keypad_model.sv */
// Operator keypad model: presses one key at a time, with release between presses
`timescale 1ns/1ps
`default_nettype none

module ssw_keypad_model (
   // Clock
   input  wire logic              ref_clk_i,
   // Key levels towards the pins
   output var ssw_pkg::ssw_keys_t keys_o
);
   initial keys_o = '0;

   // Held past the pin filter, then released so the next press is a new edge
   task automatic press(input logic [5:0] k);
      @(negedge ref_clk_i);
      keys_o = ssw_pkg::ssw_keys_t'(k);
      repeat (8) @(negedge ref_clk_i);
      keys_o = '0;
      repeat (8) @(negedge ref_clk_i);
   endtask : press
endmodule : ssw_keypad_model

`default_nettype wire

/* bench/servo_setup_bit_register_test.sv */
// Self-checking bench of the sequence setup word block
`timescale 1ns/1ps
`default_nettype none

module servo_setup_bit_register_test;
   localparam logic [5:0] K_UP = 6'h20, K_DN = 6'h10, K_LT = 6'h08;
   localparam logic [5:0] K_RT = 6'h04, K_MD = 6'h02, K_DT = 6'h01;
   logic ref_clk_i = 1'b0, reset_n_i = 1'b0;
   ssw_pkg::ssw_keys_t keys;
   ssw_pkg::ssw_pins_t pin_i;
   logic mounted = 1'b0, run = 1'b0, fwd_inh = 1'b0, rev_inh = 1'b0;
   logic [15:0] nv_rdata_i = 16'h0, stop_torque_level_i = 16'h0123;
   logic nv_blank_i = 1'b1, nv_wr_o, disp_num_view_o;
   logic [15:0] nv_wdata_o, disp_bits_o, live_word_o, stop_torque_o;
   logic [3:0] disp_bitnum_o;
   logic rotating_i = 1'b0, current_limit_i = 1'b0, dip_recover_i = 1'b0;
   logic alarm_reset_i = 1'b0, ext_alarm_i = 1'b0, abnormal_i = 1'b0;
   logic motor_stopped_i = 1'b0;
   ssw_pkg::ssw_lvl_t cmd_i = '0, switch_level_i = '0;
   logic servo_on_o, fwd_block_o, rev_block_o, motion_or_limit_flag_o, dip_alarm_o;
   logic dyn_brake_o, coast_o, pos_lock_o, ot_servo_off_o, dev_clear_o, p_only_o;
   int miscompares = 0, compares = 0, wr_count = 0, cycles = 0, w;

   assign pin_i = {keys, mounted, run, fwd_inh, rev_inh};

   ssw_keypad_model u_ssw_keypad_model (.ref_clk_i, .keys_o(keys));

   ssw_top u_ssw_top (.ref_clk_i, .reset_n_i, .pin_i, .nv_rdata_i, .nv_blank_i, .nv_wr_o,
      .nv_wdata_o, .disp_bits_o, .disp_bitnum_o, .disp_num_view_o, .live_word_o,
      .rotating_i, .current_limit_i, .dip_recover_i, .alarm_reset_i, .ext_alarm_i,
      .abnormal_i, .motor_stopped_i, .stop_torque_level_i, .cmd_i, .switch_level_i,
      .servo_on_o, .fwd_block_o, .rev_block_o, .motion_or_limit_flag_o, .dip_alarm_o,
      .dyn_brake_o, .coast_o, .stop_torque_o, .pos_lock_o, .ot_servo_off_o,
      .dev_clear_o, .p_only_o);

   ////////////////////////////////////////////////////////////////////////////////
   initial forever #4 ref_clk_i = ~ref_clk_i;

   // Commit strobe lasts one cycle, so it is counted rather than polled
   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (nv_wr_o === 1'b1)
         wr_count++;
      if (cycles == 20000)
      begin
         miscompares++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("Counts: %0d compares, %0d miscompares", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("FAIL at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask : cyc

   // A power cycle: the only way an edited word comes into force
   task automatic power_up(input logic blank, input logic [15:0] word);
      @(negedge ref_clk_i);
      reset_n_i = 1'b0;
      nv_blank_i = blank;
      nv_rdata_i = word;
      cyc(20);
      reset_n_i = 1'b1;
      cyc(10);
   endtask : power_up

   task automatic key(input logic [5:0] k);
      u_ssw_keypad_model.press(k);
      cyc(2);
   endtask : key

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_handheld();
      power_up(1'b1, 16'h0);
      key(K_DT);
      check(16'(disp_num_view_o), 16'h0);
      check(disp_bits_o, 16'h08ec);
      check(16'(disp_bitnum_o), 16'h0);
      key(K_UP);
      check(disp_bits_o, 16'h08ed);
      key(K_LT);
      check(16'(disp_bitnum_o), 16'h1);
      key(K_RT);
      check(16'(disp_bitnum_o), 16'h0);
      key(K_DN);
      check(disp_bits_o, 16'h08ec);
      key(K_UP);
      w = wr_count;
      key(K_MD);
      check(16'(wr_count - w), 16'h1);
      check(nv_wdata_o, 16'h08ed);
      check(live_word_o, 16'h08ec);
      key(K_DT);
      check(16'(disp_num_view_o), 16'h1);
      key(K_DT);
      w = wr_count;
      key(K_DT);
      check(16'(wr_count - w), 16'h1);
      key(K_DT);
      check(16'(disp_num_view_o), 16'h1);
      power_up(1'b0, 16'h08ed);
      check(live_word_o, 16'h08ed);
      check(16'(servo_on_o), 16'h1);
   endtask : test_handheld

   task automatic test_mounted();
      mounted = 1'b1;
      power_up(1'b1, 16'h0);
      key(K_DT);
      key(K_UP);
      check(16'(disp_bitnum_o), 16'h1);
      key(K_UP);
      key(K_UP);
      key(K_DN);
      check(16'(disp_bitnum_o), 16'h2);
      key(K_MD);
      check(disp_bits_o, 16'h08e8);
      w = wr_count;
      key(K_DT);
      check(16'(wr_count - w), 16'h1);
      check(nv_wdata_o, 16'h08e8);
      check(live_word_o, 16'h08ec);
      key(K_DT);
      check(16'(disp_num_view_o), 16'h1);
      mounted = 1'b0;
   endtask : test_mounted

   task automatic test_factory();
      power_up(1'b1, 16'h0);
      run = 1'b1;
      cyc(8);
      check(16'(servo_on_o), 16'h1);
      run = 1'b0;
      fwd_inh = 1'b1;
      rev_inh = 1'b1;
      rotating_i = 1'b1;
      cmd_i = {4{16'hffff}};
      dip_recover_i = 1'b1;
      cyc(1);
      dip_recover_i = 1'b0;
      cyc(8);
      check(16'(servo_on_o), 16'h0);
      check(16'(fwd_block_o), 16'h0);
      check(16'(rev_block_o), 16'h0);
      check(16'(motion_or_limit_flag_o), 16'h1);
      check(16'(p_only_o), 16'h0);
      check(16'(dip_alarm_o), 16'h0);
      {fwd_inh, rev_inh, rotating_i, cmd_i} = '0;
   endtask : test_factory

   // Bits 1 and E stay clear in every word loaded here
   task automatic test_custom();
      power_up(1'b0, 16'h00d1);
      fwd_inh = 1'b1;
      current_limit_i = 1'b1;
      cyc(8);
      check(16'(servo_on_o), 16'h1);
      check(16'(fwd_block_o), 16'h1);
      check(16'(rev_block_o), 16'h0);
      check(16'(motion_or_limit_flag_o), 16'h1);
      {fwd_inh, rev_inh, current_limit_i} = 3'b010;
      abnormal_i = 1'b1;
      cyc(8);
      check(16'(rev_block_o), 16'h1);
      check(16'(coast_o), 16'h1);
      motor_stopped_i = 1'b1;
      cyc(3);
      check(16'(dyn_brake_o), 16'h0);
      {rev_inh, abnormal_i, motor_stopped_i} = '0;
      dip_recover_i = 1'b1;
      cyc(1);
      dip_recover_i = 1'b0;
      cyc(3);
      check(16'(dip_alarm_o), 16'h1);
      check(16'(servo_on_o), 16'h0);
      check(16'(dev_clear_o), 16'h1);
      alarm_reset_i = 1'b1;
      cyc(1);
      alarm_reset_i = 1'b0;
      cyc(3);
      check(16'(dip_alarm_o), 16'h0);
   endtask : test_custom

   task automatic test_brake();
      power_up(1'b0, 16'h0180);
      abnormal_i = 1'b1;
      cyc(3);
      check(16'(dyn_brake_o), 16'h1);
      check(16'(coast_o), 16'h0);
      motor_stopped_i = 1'b1;
      cyc(3);
      check(16'(dyn_brake_o), 16'h1);
      {abnormal_i, motor_stopped_i} = '0;
      fwd_inh = 1'b1;
      cyc(8);
      check(stop_torque_o, 16'h0123);
      motor_stopped_i = 1'b1;
      cyc(3);
      check(16'(ot_servo_off_o), 16'h1);
      check(16'(pos_lock_o), 16'h0);
      power_up(1'b0, 16'h0380);
      cyc(3);
      check(16'(pos_lock_o), 16'h1);
      {fwd_inh, motor_stopped_i} = '0;
   endtask : test_brake

   // Selected quantity at its level switches and just below it does not; the others are held zero, then high, to catch a wrong pick
   task automatic test_pswitch();
      for (int sel = 0; sel < 4; sel++)
      begin
         power_up(1'b0, 16'(sel << 12));
         switch_level_i = {4{16'h0100}};
         cmd_i = '0;
         cmd_i[63 - 16 * sel -: 16] = 16'h0100;
         cyc(3);
         check(16'(p_only_o), 16'h1);
         cmd_i = {4{16'hffff}};
         cmd_i[63 - 16 * sel -: 16] = 16'h00ff;
         cyc(3);
         check(16'(p_only_o), 16'h0);
      end
      cmd_i = '0;
   endtask : test_pswitch

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      test_handheld();
      test_mounted();
      test_factory();
      test_custom();
      test_brake();
      test_pswitch();
      give_verdict();
   end
endmodule : servo_setup_bit_register_test

`default_nettype wire
